// file: eeprom_pkg.sv
// Shared constants and the pin synchroniser for the serial EEPROM slave front end
//
// Functional notes
// - Array holds 16,384 or 32,768 bytes, chosen by a parameter.
// - Up to 64 received data bytes are buffered, then committed one byte per clock during the write cycle.
// - Word pointer advances by one after every data byte moved.
// - Write protect high blocks all array changes; low allows writes everywhere.
// - Every byte travels most significant bit first.
// - Data changes only while clock is low; one bit per clock pulse.
// - Data falling while clock high is a start; every command begins with one.
// - Data rising while clock high is a stop; every operation ends with one.
// - Idle bus rests high; nobody pulls data low while idle.
// - Transmitter releases after eight bits; receiver pulls low on ninth clock.
// - No acknowledge while the internal write cycle runs.
// - Reading: release on ninth clock, sample it, send next byte if acknowledged.
// - Missing master acknowledge ends sending; wait for stop, then standby.
// - Upper four address bits must equal the device type identifier.
// - Next three address bits must equal the three select pins.
// - Eighth address bit: one means read, zero means write.
// - Write sends high word address, low word address, then data.
// - Matching write address is acknowledged, then both address bytes and data.
// - Internal write cycle starts at the stop ending a write.
// - During the write cycle all inputs are ignored, nothing answered.
// - Page write takes up to sixty-three more bytes, each acknowledged.
// - Under write protect bytes are acknowledged but stop starts no write.

package eeprom_pkg;
    localparam int        MEM_BYTES_DEF = 32768;
    localparam int        MEM_BYTES_ALT = 16384;
    localparam int        PAGE_BYTES    = 64;
    localparam int        PAGE_W        = 6;
    localparam logic [3:0] BYTE_LAST    = 4'h7;
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    // Identifier default is arbitrary, set the real one per product
    localparam logic [3:0] DEV_ID_DEF   = 4'h6;
    // Write cycle time in ms and clock in MHz, cycles derived from both
    localparam int        T_WR_MS       = 5;
    localparam int        CLK_MHZ       = 40;
    localparam int        WR_CYC_DEF    = T_WR_MS * CLK_MHZ * 1000;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ADDR   = 7'h02,
        ST_WHI    = 7'h04,
        ST_WLO    = 7'h08,
        ST_WDATA  = 7'h10,
        ST_RDATA  = 7'h20,
        ST_IGNORE = 7'h40
    } state_t;
endpackage

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser plus one delayed copy for edge detection
module pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_lvl,
    output logic      [W-1:0] o_prev
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_q <= RST_VAL;
            o_lvl  <= RST_VAL;
            o_prev <= RST_VAL;
        end
        else
        begin
            meta_q <= i_async;
            o_lvl  <= meta_q;
            o_prev <= o_lvl;
        end
    end
endmodule // pin_sync

// file: eeprom_slave.sv
// Two-wire serial EEPROM slave: bus protocol, page buffer, array and write cycle
`timescale 1ns/1ps

module eeprom_slave #(
    parameter int         MEM_BYTES = eeprom_pkg::MEM_BYTES_DEF,
    parameter int         WR_CYCLES = eeprom_pkg::WR_CYC_DEF,
    parameter logic [3:0] DEV_ID    = eeprom_pkg::DEV_ID_DEF
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_wp,
    input  wire logic [2:0] i_device_select_pins,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    output logic            o_busy
);
    import eeprom_pkg::*;

    localparam int AW  = $clog2(MEM_BYTES);
    localparam int WCW = $clog2(WR_CYCLES + 1);
    localparam int IXW = PAGE_W + 1;

    // Only the two documented capacities, and a cycle long enough to commit a page
    if (MEM_BYTES != MEM_BYTES_DEF && MEM_BYTES != MEM_BYTES_ALT)
        $error("MEM_BYTES must be 16384 or 32768");
    if (WR_CYCLES <= PAGE_BYTES)
        $error("WR_CYCLES must exceed the page size");

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling
    logic       scl_s;
    logic       scl_p;
    logic       sda_s;
    logic       sda_p;
    logic       wp_s;
    logic [2:0] sel_s;

    // Bus pins rest high and need the delayed copy for edge detection
    pin_sync #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync_bus (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async ({i_scl, i_sda}),
        .o_lvl   ({scl_s, sda_s}),
        .o_prev  ({scl_p, sda_p})
    );

    // Strap pins only need their level; no edge is ever taken from them
    pin_sync #(
        .W       (4),
        .RST_VAL (4'h0)
    ) u_sync_cfg (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async ({i_wp, i_device_select_pins}),
        .o_lvl   ({wp_s, sel_s}),
        .o_prev  ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and storage
    state_t           state_q;
    state_t           state_d;
    logic [3:0]       cnt_q;
    logic [7:0]       rx_q;
    logic [7:0]       tx_q;
    logic [7:0]       hi_q;
    logic [AW-1:0]    ptr_q;
    logic             ack_q;
    logic             oe_n_q;
    logic             oe_n_d;
    logic             sda_q;
    logic             busy_q;
    logic [WCW-1:0]   wr_cnt_q;
    logic [IXW-1:0]   idx_q;
    logic [AW-PAGE_W-1:0] page_q;
    logic [PAGE_BYTES-1:0] vld_q;
    logic [7:0]       pbuf [PAGE_BYTES];
    logic [7:0]       mem  [MEM_BYTES];

    // Page wrap keeps the upper bits, so a long write overwrites earlier bytes
    function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] p);
        page_inc = {p[AW-1:PAGE_W], p[PAGE_W-1:0] + 1'b1};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus event decode; events are void while the write cycle runs
    wire        scl_rise   = scl_s & ~scl_p;
    wire        scl_fall   = ~scl_s & scl_p;
    wire        start_ev   = scl_s & scl_p & sda_p & ~sda_s;
    wire        stop_ev    = scl_s & scl_p & ~sda_p & sda_s;
    wire        live       = ~busy_q;
    wire        byte_done  = live & scl_rise & (cnt_q == BYTE_LAST);
    wire        nine_rise  = live & scl_rise & (cnt_q == ACK_SLOT);
    wire [7:0]  rx_full    = {rx_q[6:0], sda_s};
    wire        id_ok      = rx_full[7:4] == DEV_ID;
    wire        sel_ok     = rx_full[3:1] == sel_s;
    wire        addr_match = id_ok & sel_ok;
    wire        is_read    = rx_full[0];
    wire        rd_state   = state_q == ST_RDATA;
    wire        tx_bit     = tx_q[3'(4'h7 - cnt_q)];
    wire        mst_ack    = nine_rise & rd_state & ~ack_q;
    wire [15:0] word_addr  = {hi_q, rx_full};
    wire [AW-1:0] ptr_next = ptr_q + 1'b1;
    wire        commit_go  = live & stop_ev & (|vld_q) & ~wp_s;
    wire        commit_en  = busy_q & ~idx_q[PAGE_W] & vld_q[idx_q[PAGE_W-1:0]];
    wire        cycle_end  = busy_q & (wr_cnt_q == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        state_d = state_q;
        if (busy_q)
            state_d = ST_IDLE;
        else if (start_ev)
            state_d = ST_ADDR;
        else if (stop_ev)
            state_d = ST_IDLE;
        else if (byte_done)
        begin
            unique case (state_q)
                ST_ADDR:   state_d = !addr_match ? ST_IGNORE :
                                     (is_read ? ST_RDATA : ST_WHI);
                ST_WHI:    state_d = ST_WLO;
                ST_WLO:    state_d = ST_WDATA;
                ST_WDATA:  state_d = ST_WDATA;
                ST_RDATA:  state_d = ST_RDATA;
                ST_IDLE:   state_d = ST_IDLE;
                ST_IGNORE: state_d = ST_IGNORE;
            endcase
        end
        else if (mst_ack && sda_s)
            state_d = ST_IGNORE;
    end

    // Data pin: change only after the clock falls, release on events
    always_comb
    begin
        oe_n_d = oe_n_q;
        if (busy_q || start_ev || stop_ev)
            oe_n_d = 1'b1;
        else if (scl_fall)
            oe_n_d = (cnt_q == ACK_SLOT) ? ~ack_q :
                     ~(rd_state & ~ack_q & ~tx_bit);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= ST_IDLE;
            oe_n_q  <= 1'b1;
            sda_q   <= 1'b0;
            cnt_q   <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            oe_n_q  <= oe_n_d;
            sda_q   <= 1'b0;
            if (busy_q || start_ev || stop_ev)
                cnt_q <= 4'h0;
            else if (scl_rise)
                cnt_q <= (cnt_q == ACK_SLOT) ? 4'h0 : cnt_q + 4'h1;
        end
    end

    // Shift register and acknowledge decision per byte
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_q  <= 8'h00;
            ack_q <= 1'b0;
        end
        else
        begin
            if (live && scl_rise && cnt_q < ACK_SLOT)
                rx_q <= rx_full;
            if (start_ev || stop_ev || nine_rise || busy_q)
                ack_q <= 1'b0;
            else if (byte_done)
                ack_q <= (state_q == ST_ADDR) ? addr_match :
                         (state_q == ST_WHI || state_q == ST_WLO ||
                          state_q == ST_WDATA);
        end
    end

    // Word address pointer and outgoing byte
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hi_q  <= 8'h00;
            ptr_q <= '0;
            tx_q  <= 8'h00;
        end
        else if (byte_done)
        begin
            if (state_q == ST_WHI)
                hi_q <= rx_full;
            if (state_q == ST_WLO)
                ptr_q <= word_addr[AW-1:0];
            if (state_q == ST_WDATA)
                ptr_q <= page_inc(ptr_q);
            if (state_q == ST_ADDR)
                tx_q <= mem[ptr_q];
        end
        else if (mst_ack)
        begin
            ptr_q <= ptr_next;
            tx_q  <= mem[ptr_next];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page buffer fill and write cycle timer
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            vld_q    <= '0;
            page_q   <= '0;
            busy_q   <= 1'b0;
            wr_cnt_q <= '0;
            idx_q    <= '0;
        end
        else if (busy_q)
        begin
            wr_cnt_q <= wr_cnt_q - 1'b1;
            if (!idx_q[PAGE_W])
                idx_q <= idx_q + 1'b1;
            if (cycle_end)
            begin
                busy_q <= 1'b0;
                vld_q  <= '0;
            end
        end
        else if (commit_go)
        begin
            busy_q   <= 1'b1;
            wr_cnt_q <= WCW'(WR_CYCLES - 1);
            idx_q    <= '0;
        end
        else if (start_ev || stop_ev)
            vld_q <= '0;
        else if (byte_done && state_q == ST_WDATA)
        begin
            vld_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
            page_q <= ptr_q[AW-1:PAGE_W];
        end
    end

    // Buffer and array contents hold no reset; the array is non-volatile
    always_ff @(posedge i_mclk)
    begin
        if (!busy_q && byte_done && state_q == ST_WDATA)
            pbuf[ptr_q[PAGE_W-1:0]] <= rx_full;
        if (commit_en)
            mem[{page_q, idx_q[PAGE_W-1:0]}] <= pbuf[idx_q[PAGE_W-1:0]];
    end

    assign o_sda      = sda_q;
    assign o_sda_oe_n = oe_n_q;
    assign o_busy     = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_busy_no_drive: assert property (busy_q |-> o_sda_oe_n)
        else $error("data pin driven during write cycle");
    a_idle_released: assert property ($past(state_q == ST_IDLE) && state_q == ST_IDLE
                                      |-> o_sda_oe_n)
        else $error("data pin driven while idle");
    a_stop_commits: assert property (commit_go |=> busy_q && wr_cnt_q == WCW'(WR_CYCLES - 1))
        else $error("stop did not start write cycle");
    a_wp_blocks: assert property (!busy_q && stop_ev && wp_s |=> !busy_q)
        else $error("write cycle started under protection");
    a_start_rearms: assert property (live && start_ev |=> state_q == ST_ADDR && cnt_q == 4'h0)
        else $error("start did not rearm address phase");
    a_mismatch_quiet: assert property (state_q == ST_IGNORE |-> o_sda_oe_n)
        else $error("driving after mismatch or nack");
    a_ack_driven: assert property (live && scl_fall && cnt_q == ACK_SLOT && ack_q
                                   && !start_ev && !stop_ev |=> !o_sda_oe_n)
        else $error("acknowledge not driven");
    a_msb_first: assert property (live && scl_fall && rd_state && cnt_q < ACK_SLOT
                                  && !start_ev && !stop_ev |=> o_sda_oe_n == $past(tx_bit))
        else $error("read bit out of order");
    a_page_incr: assert property (byte_done && state_q == ST_WDATA
                                  |=> ptr_q[PAGE_W-1:0] == $past(ptr_q[PAGE_W-1:0]) + 1'b1)
        else $error("pointer not advanced in page");
    a_busy_holds: assert property (busy_q && wr_cnt_q != '0 |=> busy_q)
        else $error("write cycle ended early");
    a_read_nack: assert property (mst_ack && sda_s && !start_ev && !stop_ev
                                  |=> state_q == ST_IGNORE ##1 o_sda_oe_n)
        else $error("kept sending after nack");

    c_write_cycle: cover property (commit_go ##1 busy_q);
    c_read_ack:    cover property (mst_ack && !sda_s);
    c_wp_stop:     cover property (live && stop_ev && wp_s && (|vld_q));
    c_mismatch:    cover property (byte_done && state_q == ST_ADDR && !addr_match);
endmodule // eeprom_slave

// file: i2c_master_model.sv
// Behavioural two-wire bus master that makes the serial clock and drives data
`timescale 1ns/1ps

module i2c_master_model (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe_n
);
    // Idle bus: clock stands high and data is released between frames
    initial
    begin
        o_scl      = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every change lands just after a falling edge of the system clock
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    // One clock pulse of 8 mclk; data moves mid-low, sampled late in high
    task automatic xfer(input logic b, output logic r);
        tick(2);
        o_sda_oe_n = b;
        tick(2);
        o_scl = 1'b1;
        tick(3);
        r = i_sda;
        tick(1);
        o_scl = 1'b0;
    endtask

    // Longer low phase so the slave has surely let go of data first
    task automatic start();
        tick(2);
        o_sda_oe_n = 1'b1;
        tick(3);
        o_scl = 1'b1;
        tick(4);
        o_sda_oe_n = 1'b0;
        tick(4);
        o_scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        o_sda_oe_n = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_oe_n = 1'b1;
        tick(4);
    endtask

    // Eight bits out, then release and sample the receiver's answer
    task automatic write_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(d[i], r);
        xfer(1'b1, ack_n);
    endtask

    // Byte count is the caller's choice; ack_n low asks for another byte
    task automatic read_byte(input logic ack_n, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(1'b1, d[i]);
        xfer(ack_n, r);
    endtask
endmodule // i2c_master_model

// file: testbench.sv
// Self-checking bench for the serial EEPROM slave against a behavioural master
`timescale 1ns/1ps

module testbench;
    localparam int         WR_CYC = 200;
    localparam logic [7:0] SLV_W  = 8'hca;
    localparam logic [7:0] SLV_R  = 8'hcb;

    logic      i_mclk;
    logic      i_rst_n;
    logic      i_wp;
    logic [2:0] sel;
    logic      scl;
    logic      m_oe_n;
    logic      o_sda;
    logic      o_sda_oe_n;
    logic      o_busy;
    wire logic sda_line;
    int        err_total;
    int        tests_run;
    int        busy_run;
    int        busy_len;

    // Open-drain wire with pull-up: released by both means high
    assign sda_line = !m_oe_n ? 1'b0 : (!o_sda_oe_n ? o_sda : 1'b1);

    // Identifier value is arbitrary; it forms the upper nibble of SLV_W and SLV_R
    eeprom_slave #(.MEM_BYTES(16384), .WR_CYCLES(WR_CYC), .DEV_ID(4'hc)) DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line), .i_wp(i_wp),
        .i_device_select_pins(sel), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));

    i2c_master_model master (.i_mclk(i_mclk), .i_sda(sda_line), .o_scl(scl),
                             .o_sda_oe_n(m_oe_n));

    initial
    begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    // Length of the latest write cycle in clock periods, sampled where settled
    always @(negedge i_mclk)
    begin
        if (o_busy === 1'b1)
            busy_run <= busy_run + 1;
        else if (busy_run != 0)
        begin
            busy_len <= busy_run;
            busy_run <= 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic send(input string what, input logic [7:0] d, input logic exp);
        logic r;
        master.write_byte(d, r);
        check(what, 16'(exp), 16'(r));
    endtask

    // Bounded wait on the busy level; running out ends the run
    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (o_busy !== v && n < lim)
        begin
            @(negedge i_mclk);
            n++;
        end
        if (o_busy !== v)
        begin
            $display("Error busy_wait expected %b seen %b", v, o_busy);
            err_total++;
            report_and_stop();
        end
    endtask

    // Dummy write sets the pointer, repeated start reads one byte
    task automatic rd_at(input logic [7:0] hi, input logic [7:0] lo, output logic [7:0] d);
        master.start();
        send("ack_w", SLV_W, 1'b0);
        send("ack_hi", hi, 1'b0);
        send("ack_lo", lo, 1'b0);
        master.start();
        send("ack_r", SLV_R, 1'b0);
        master.read_byte(1'b1, d);
        check("nack_release", 16'h1, 16'(o_sda_oe_n));
        master.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_page();
        master.start();
        send("ack_w", SLV_W, 1'b0);
        send("ack_hi", 8'h01, 1'b0);
        send("ack_lo", 8'h00, 1'b0);
        send("ack_d0", 8'ha5, 1'b0);
        send("ack_d1", 8'h3c, 1'b0);
        send("ack_d2", 8'h81, 1'b0);
        master.stop();
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 1000);
        // Busy rises before the stop task returns, so the monitor keeps the count
        repeat (2) @(negedge i_mclk);
        check("busy_len", 16'(WR_CYC), 16'(busy_len));
        $display("Test page_write done");
    endtask

    task automatic t_read();
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
        master.start();
        send("ack_w", SLV_W, 1'b0);
        send("ack_hi", 8'h01, 1'b0);
        send("ack_lo", 8'h00, 1'b0);
        master.start();
        send("ack_r", SLV_R, 1'b0);
        master.read_byte(1'b0, d0);
        master.read_byte(1'b1, d1);
        master.stop();
        check("rd_d0", 16'h00a5, 16'(d0));
        check("rd_d1", 16'h003c, 16'(d1));
        // Current-address read picks up after the nacked byte
        master.start();
        send("ack_r", SLV_R, 1'b0);
        master.read_byte(1'b1, d2);
        master.stop();
        check("rd_cur", 16'h0081, 16'(d2));
        $display("Test read_back done");
    endtask

    task automatic t_mismatch();
        master.start();
        send("nack_id", 8'h9a, 1'b1);
        send("nack_more", 8'h00, 1'b1);
        master.stop();
        sel = 3'h2;
        master.start();
        send("nack_sel", SLV_W, 1'b1);
        master.stop();
        sel = 3'h5;
        master.tick(4);
        $display("Test mismatch done");
    endtask

    task automatic t_protect();
        logic [7:0] d;
        int         hits;
        i_wp = 1'b1;
        master.start();
        send("ack_w", SLV_W, 1'b0);
        send("ack_hi", 8'h01, 1'b0);
        send("ack_lo", 8'h00, 1'b0);
        send("ack_d", 8'h77, 1'b0);
        master.stop();
        hits = 0;
        repeat (40)
        begin
            @(negedge i_mclk);
            if (o_busy !== 1'b0)
                hits++;
        end
        check("busy_wp", 16'h0, 16'(hits));
        i_wp = 1'b0;
        rd_at(8'h01, 8'h00, d);
        check("wp_keep", 16'h00a5, 16'(d));
        $display("Test protect done");
    endtask

    // 65 bytes into one page: the last lands on the first slot
    task automatic t_wrap();
        logic [7:0] d;
        master.start();
        send("ack_w", SLV_W, 1'b0);
        send("ack_hi", 8'hc2, 1'b0);
        send("ack_lo", 8'h00, 1'b0);
        for (int k = 0; k < 65; k++)
            send("ack_pg", 8'(k), 1'b0);
        master.stop();
        wait_busy(1'b1, 20);
        master.start();
        send("nack_busy", SLV_W, 1'b1);
        master.stop();
        wait_busy(1'b0, 300);
        rd_at(8'h02, 8'h00, d);
        check("wrap_d0", 16'h0040, 16'(d));
        rd_at(8'h02, 8'h01, d);
        check("wrap_d1", 16'h0001, 16'(d));
        $display("Test page_wrap done");
    endtask

    // A start in mid-byte must restart the address byte
    task automatic t_restart();
        logic [7:0] d;
        logic       r;
        master.start();
        for (int i = 0; i < 4; i++)
            master.xfer(1'b1, r);
        rd_at(8'h01, 8'h02, d);
        check("restart_rd", 16'h0081, 16'(d));
        $display("Test restart done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial
    begin
        repeat (100000) @(posedge i_mclk);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        err_total = 0;
        tests_run = 0;
        i_rst_n   = 1'b0;
        i_wp      = 1'b0;
        sel       = 3'h5;
        repeat (20) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_mclk);
        check("idle_oe_n", 16'h1, 16'(o_sda_oe_n));
        check("idle_busy", 16'h0, 16'(o_busy));
        t_page();
        t_read();
        t_mismatch();
        t_protect();
        t_wrap();
        t_restart();
        report_and_stop();
    end
endmodule // testbench
